// >>> hdl/setpoint_store.sv
`timescale 1ns/1ps
`default_nettype none
module setpoint_store #(
   parameter int WIDTH = vout_regs_pkg::MANT_W,
   parameter int DEPTH = 3
) (
   input wire logic i_sys_clk,
   input wire logic i_resetn,
   input wire vout_regs_pkg::sp_write_t i_wr,
   input wire logic [1:0] i_bus_addr,
   output logic [WIDTH-1:0] o_bus_data,
   input wire logic [1:0] i_act_addr,
   output logic [WIDTH-1:0] o_act_data
);
   import vout_regs_pkg::*;

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [WIDTH-1:0] bus_q;
      logic [WIDTH-1:0] act_q;
   } store_t;

   store_t s_r;
   store_t s_nxt;

   // Out-of-range slots read zero rather than wrap
   function automatic logic [WIDTH-1:0] rd(input store_t s, input logic [1:0] a);
      logic [WIDTH-1:0] d;
      d = '0;
      if (int'(a) < DEPTH) d = s.mem[a];
      return d;
   endfunction

   // Write port and two registered read ports
   always_comb begin
      s_nxt = s_r;
      if (i_wr.we && int'(i_wr.addr) < DEPTH) s_nxt.mem[i_wr.addr] = i_wr.data;
      s_nxt.bus_q = rd(s_r, i_bus_addr);
      s_nxt.act_q = rd(s_r, i_act_addr);
   end

   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) s_r <= '0;
      else s_r <= s_nxt;
   end

   assign o_bus_data = s_r.bus_q;
   assign o_act_data = s_r.act_q;
endmodule // setpoint_store
`default_nettype wire

// >>> hdl/vout_regs_pkg.sv
// Behaviour
// - Format register reads 0x17: linear, exponent -9
// - Output volts equal mantissa times two^-9
// - Setpoints ten bits effective, 307 to 614; the code stores any ten-bit code without a range check
// - Reference moves one step per strapped interval
// - Margin-high setpoint drives output when selected
// - Margin-low setpoint drives output when selected
// - Setpoints travel as two bytes, low first
// - Off flag low while output actively driven
// - Off flag high when off or tri-stated
// - Bit 5 latches output overvoltage fault
// - Bit 4 latches output overcurrent fault
// - Bit 3 latches input undervoltage fault
// - Bit 2 latches temperature fault or warning
// - Bit 1 latches communication, memory, logic fault
// - Bit 0 latches any other fault
// - Clear-faults empties status, releases alert, persisting refire
// - Margin field picks low, high or nominal
package vout_regs_pkg;
   // Command codes on the two-wire bus
   localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
   localparam logic [7:0] CMD_VOUT_FORMAT = 8'h20;
   localparam logic [7:0] CMD_VOUT_SETPOINT = 8'h21;
   localparam logic [7:0] CMD_MARGIN_HIGH = 8'h25;
   localparam logic [7:0] CMD_MARGIN_LOW = 8'h26;
   localparam logic [7:0] CMD_STATUS = 8'h78;
   // Linear mode 000, exponent 10111
   localparam logic [7:0] FORMAT_VALUE = 8'h17;
   localparam int MANT_W = 10;
   // Setpoint store slots
   localparam logic [1:0] IDX_NOM = 2'h0;
   localparam logic [1:0] IDX_MHIGH = 2'h1;
   localparam logic [1:0] IDX_MLOW = 2'h2;
   // Margin field codes
   localparam logic [3:0] MARGIN_LOW_A = 4'h5;
   localparam logic [3:0] MARGIN_LOW_B = 4'h6;
   localparam logic [3:0] MARGIN_HIGH_A = 4'h9;
   localparam logic [3:0] MARGIN_HIGH_B = 4'ha;
   // Strap reset values of the setpoints, 0.6 V to 1.0 V
   localparam logic [9:0] STRAP_VOUT_0 = 10'h133;
   localparam logic [9:0] STRAP_VOUT_1 = 10'h180;
   localparam logic [9:0] STRAP_VOUT_2 = 10'h1cd;
   localparam logic [9:0] STRAP_VOUT_3 = 10'h200;
   // Step interval: base time in us, rate in MHz; exact product
   localparam int CLK_MHZ = 25;
   localparam int STEP_BASE_US = 4;
   localparam int STEP_BASE_CYC = STEP_BASE_US * CLK_MHZ;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [3:0] INIT_DONE_STEP = 4'h3;

   typedef enum logic [8:0] {
      S_IDLE = 9'h001,
      S_ADDR = 9'h002,
      S_ADDR_ACK = 9'h004,
      S_CMD = 9'h008,
      S_CMD_ACK = 9'h010,
      S_WDATA = 9'h020,
      S_WDATA_ACK = 9'h040,
      S_RDATA = 9'h080,
      S_RDATA_ACK = 9'h100
   } bus_state_t;

   // Fault detector levels, in status bit order 5 down to 0
   typedef struct packed {
      logic ov;
      logic oc;
      logic vin_uv;
      logic temp;
      logic cml;
      logic other;
   } fault_t;

   typedef struct packed {
      logic we;
      logic [1:0] addr;
      logic [MANT_W-1:0] data;
   } sp_write_t;
endpackage

// >>> hdl/vout_setpoint_and_status_regs.sv
`timescale 1ns/1ps
`default_nettype none
module vout_setpoint_and_status_regs #(
   parameter logic [6:0] DEV_ADDR = 7'h2a
) (
   input wire logic i_sys_clk,
   input wire logic i_resetn,
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_sda,
   output logic o_sda_oe_n,
   output logic o_alert_n,
   input wire logic [1:0] i_strap_slew,
   input wire logic [1:0] i_strap_vout,
   input wire logic i_on_cmd,
   input wire logic [3:0] i_margin_sel,
   input wire logic i_tristated,
   input wire vout_regs_pkg::fault_t i_faults,
   output logic [9:0] o_vref,
   output logic [7:0] o_status
);
   import vout_regs_pkg::*;

   typedef struct packed {
      bus_state_t st;
      logic [2:0] scl_sy;
      logic [2:0] sda_sy;
      logic scl_f;
      logic sda_f;
      logic [3:0] bitcnt;
      logic [7:0] shreg;
      logic [7:0] cmd;
      logic rw;
      logic [1:0] nbytes;
      logic [7:0] lo;
      logic [15:0] rdword;
      logic sda_oe_n;
      logic drv_low;
      logic [5:0] sticky;
      logic off;
      logic alert_n;
      logic [1:0] slew;
      logic [3:0] init;
      logic init_done;
      sp_write_t wr;
      logic [9:0] vref;
      logic [9:0] step_cnt;
   } regs_t;

   regs_t r;
   regs_t n;
   logic [9:0] bus_data;
   logic [9:0] act_data;
   logic [1:0] act_idx;
   logic [5:0] fault_vec;
   logic scl_new;
   logic sda_new;
   logic rise;
   logic fall;
   logic start;
   logic stop;
   logic clear;
   logic rd_load;
   logic load_byte;

   ////////////////////////////////////////////////////////////
   // Decode helpers

   function automatic logic is_sp(input logic [7:0] c);
      return c == CMD_VOUT_SETPOINT || c == CMD_MARGIN_HIGH || c == CMD_MARGIN_LOW;
   endfunction

   function automatic logic [1:0] sp_index(input logic [7:0] c);
      logic [1:0] i;
      i = IDX_NOM;
      if (c == CMD_MARGIN_HIGH) i = IDX_MHIGH;
      else if (c == CMD_MARGIN_LOW) i = IDX_MLOW;
      return i;
   endfunction

   // Margin only applies while the unit is commanded on
   function automatic logic [1:0] pick(input logic on, input logic [3:0] m);
      logic [1:0] i;
      i = IDX_NOM;
      if (on && (m == MARGIN_LOW_A || m == MARGIN_LOW_B)) i = IDX_MLOW;
      else if (on && (m == MARGIN_HIGH_A || m == MARGIN_HIGH_B)) i = IDX_MHIGH;
      return i;
   endfunction

   function automatic logic [9:0] strap_vout(input logic [1:0] s);
      logic [9:0] v;
      v = STRAP_VOUT_0;
      if (s == 2'h1) v = STRAP_VOUT_1;
      else if (s == 2'h2) v = STRAP_VOUT_2;
      else if (s == 2'h3) v = STRAP_VOUT_3;
      return v;
   endfunction

   // Unknown commands read as zero
   function automatic logic [15:0] read_word(input logic [7:0] c, input logic [9:0] sp,
                                             input logic [7:0] sb);
      logic [15:0] w;
      w = 16'h0000;
      if (c == CMD_VOUT_FORMAT) w = {8'h00, FORMAT_VALUE};
      else if (is_sp(c)) w = {6'h00, sp};
      else if (c == CMD_STATUS) w = {8'h00, sb};
      return w;
   endfunction

   ////////////////////////////////////////////////////////////
   // Setpoint storage

   assign fault_vec = i_faults;
   assign act_idx = pick(i_on_cmd, i_margin_sel);

   setpoint_store #(
      .WIDTH(MANT_W),
      .DEPTH(3)
   ) u_store (
      .i_sys_clk(i_sys_clk),
      .i_resetn(i_resetn),
      .i_wr(r.wr),
      .i_bus_addr(sp_index(r.cmd)),
      .o_bus_data(bus_data),
      .i_act_addr(act_idx),
      .o_act_data(act_data)
   );

   ////////////////////////////////////////////////////////////
   // Next state: line filter, bus slave, status, stepping

   always_comb begin
      n = r;
      n.wr.we = 1'b0;
      clear = 1'b0;
      rd_load = 1'b0;
      load_byte = 1'b0;
      // Three-stage sync; level counts once stages 2 and 3 agree
      n.scl_sy = {r.scl_sy[1:0], i_scl};
      n.sda_sy = {r.sda_sy[1:0], i_sda};
      scl_new = (r.scl_sy[2] == r.scl_sy[1]) ? r.scl_sy[2] : r.scl_f;
      sda_new = (r.sda_sy[2] == r.sda_sy[1]) ? r.sda_sy[2] : r.sda_f;
      n.scl_f = scl_new;
      n.sda_f = sda_new;
      rise = !r.scl_f && scl_new;
      fall = r.scl_f && !scl_new;
      start = r.scl_f && scl_new && r.sda_f && !sda_new;
      stop = r.scl_f && scl_new && !r.sda_f && sda_new;

      // Power-up: catch straps, preload all three setpoints
      if (!r.init_done) begin
         n.init = r.init + 4'h1;
         n.wr.we = (r.init < INIT_DONE_STEP);
         n.wr.addr = r.init[1:0];
         n.wr.data = strap_vout(i_strap_vout);
         if (r.init == 4'h0) n.slew = i_strap_slew;
         n.vref = strap_vout(i_strap_vout);
         n.init_done = (r.init == INIT_DONE_STEP);
      end else if (start) begin
         n.st = S_ADDR;
         n.bitcnt = 4'h0;
         n.sda_oe_n = 1'b1;
      end else if (stop) begin
         // Send-byte form: command code with no data bytes
         clear = (r.st == S_WDATA) && (r.nbytes == 2'h0) && (r.cmd == CMD_CLEAR_FAULTS);
         n.st = S_IDLE;
         n.sda_oe_n = 1'b1;
      end else begin
         unique case (r.st)
            S_IDLE: begin
               n.sda_oe_n = 1'b1;
            end
            S_ADDR, S_CMD, S_WDATA: begin
               if (rise) begin
                  n.shreg = {r.shreg[6:0], sda_new};
                  n.bitcnt = r.bitcnt + 4'h1;
               end else if (fall && r.bitcnt == BITS_PER_BYTE) begin
                  n.sda_oe_n = 1'b0;
                  n.bitcnt = 4'h0;
                  if (r.st == S_ADDR) begin
                     // Foreign address: stay off the line until next start
                     n.sda_oe_n = (r.shreg[7:1] != DEV_ADDR);
                     n.st = (r.shreg[7:1] == DEV_ADDR) ? S_ADDR_ACK : S_IDLE;
                     n.rw = r.shreg[0];
                     rd_load = (r.shreg[7:1] == DEV_ADDR) && r.shreg[0];
                     n.rdword = read_word(r.cmd, bus_data, o_status);
                  end else if (r.st == S_CMD) begin
                     n.cmd = r.shreg;
                     n.nbytes = 2'h0;
                     n.st = S_CMD_ACK;
                  end else begin
                     // Low byte first, high byte commits the word
                     if (r.nbytes == 2'h0) n.lo = r.shreg;
                     n.wr.we = (r.nbytes == 2'h1) && is_sp(r.cmd);
                     n.wr.addr = sp_index(r.cmd);
                     n.wr.data = {r.shreg[1:0], r.lo};
                     if (r.nbytes != 2'h3) n.nbytes = r.nbytes + 2'h1;
                     n.st = S_WDATA_ACK;
                  end
               end
            end
            S_ADDR_ACK, S_CMD_ACK, S_WDATA_ACK: begin
               if (fall) begin
                  n.sda_oe_n = 1'b1;
                  n.st = (r.st == S_CMD_ACK || r.st == S_WDATA_ACK) ? S_WDATA : S_CMD;
                  load_byte = (r.st == S_ADDR_ACK) && r.rw;
               end
            end
            S_RDATA: begin
               if (fall && r.bitcnt == BITS_PER_BYTE) begin
                  n.sda_oe_n = 1'b1;
                  n.st = S_RDATA_ACK;
               end else if (fall) begin
                  n.sda_oe_n = r.shreg[7];
                  n.shreg = {r.shreg[6:0], 1'b0};
                  n.bitcnt = r.bitcnt + 4'h1;
               end
            end
            S_RDATA_ACK: begin
               // Host nack ends the read; ack asks for the next byte
               if (rise && sda_new) n.st = S_IDLE;
               else if (fall) load_byte = 1'b1;
            end
         endcase
      end

      // Shift out the next read byte, low byte of the word first
      if (load_byte) begin
         n.st = S_RDATA;
         n.sda_oe_n = r.rdword[7];
         n.shreg = {r.rdword[6:0], 1'b0};
         n.rdword = {8'h00, r.rdword[15:8]};
         n.bitcnt = 4'h1;
      end

      // Sticky faults; an event in the clear cycle survives it
      n.sticky = (clear ? 6'h00 : r.sticky) | fault_vec;
      n.off = !i_on_cmd || i_tristated;
      n.alert_n = !((!r.alert_n && !clear) || |(fault_vec & (clear ? 6'h3f : ~r.sticky)));

      // One code step per interval; the first step of a move is immediate
      if (r.init_done) begin
         if (r.step_cnt != 10'h000) begin
            n.step_cnt = r.step_cnt - 10'h001;
         end else if (r.vref != act_data) begin
            n.vref = (r.vref < act_data) ? r.vref + 10'h001 : r.vref - 10'h001;
            n.step_cnt = 10'((STEP_BASE_CYC << r.slew) - 1);
         end
      end
   end

   ////////////////////////////////////////////////////////////
   // State register; lines idle high after reset

   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         r <= '0;
         r.st <= S_IDLE;
         r.scl_sy <= 3'h7;
         r.sda_sy <= 3'h7;
         r.scl_f <= 1'b1;
         r.sda_f <= 1'b1;
         r.sda_oe_n <= 1'b1;
         r.alert_n <= 1'b1;
         r.off <= 1'b1;
      end else begin
         r <= n;
      end
   end

   // Open-drain: data is always low, enable decides
   assign o_sda = r.drv_low;
   assign o_sda_oe_n = r.sda_oe_n;
   assign o_alert_n = r.alert_n;
   assign o_vref = r.vref;
   assign o_status = {1'b0, r.off, r.sticky};

   ////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (!i_resetn);

   sequence s_step_due;
      r.init_done && r.step_cnt == 10'h000 && r.vref != act_data;
   endsequence

   sequence s_fmt_load;
      rd_load && r.cmd == CMD_VOUT_FORMAT;
   endsequence

   property p_fmt_read;
      s_fmt_load |=> r.rdword == 16'h0017;
   endproperty
   a_fmt_read: assert property (p_fmt_read) else $error("format word not 0x17");

   property p_step_size;
      r.init_done && $past(r.init_done) && $changed(r.vref) |->
         $past(r.step_cnt) == 10'h000 &&
         (r.vref == $past(r.vref) + 10'h001 || r.vref == $past(r.vref) - 10'h001);
   endproperty
   a_step_size: assert property (p_step_size) else $error("reference jumped");

   // The step lands on the edge after it falls due, then a quiet gap follows
   property p_step_gap;
      s_step_due |=> $changed(r.vref) ##1 $stable(r.vref)[*8];
   endproperty
   a_step_gap: assert property (p_step_gap) else $error("steps too close");

   property p_sticky_set;
      fault_vec != 6'h00 |=> (r.sticky & $past(fault_vec)) == $past(fault_vec);
   endproperty
   a_sticky_set: assert property (p_sticky_set) else $error("fault not latched");

   property p_clear;
      clear && fault_vec == 6'h00 |=> r.sticky == 6'h00 && r.alert_n;
   endproperty
   a_clear: assert property (p_clear) else $error("clear did not empty status");

   property p_off_low;
      i_on_cmd && !i_tristated |=> !o_status[6];
   endproperty
   a_off_low: assert property (p_off_low) else $error("off set while driven");

   property p_off_high;
      !i_on_cmd || i_tristated |=> o_status[6];
   endproperty
   a_off_high: assert property (p_off_high) else $error("off clear while off");

   property p_status_top;
      rd_load && r.cmd == CMD_STATUS |=> r.rdword[15:7] == 9'h000;
   endproperty
   a_status_top: assert property (p_status_top) else $error("status top bits set");

   property p_sp_width;
      rd_load && is_sp(r.cmd) |=> r.rdword[15:10] == 6'h00;
   endproperty
   a_sp_width: assert property (p_sp_width) else $error("setpoint upper bits set");

   property p_margin_high;
      i_on_cmd && i_margin_sel == MARGIN_HIGH_A |-> act_idx == IDX_MHIGH;
   endproperty
   a_margin_high: assert property (p_margin_high) else $error("margin high not chosen");
endmodule // vout_setpoint_and_status_regs
`default_nettype wire

// >>> testbench/pmbus_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// Host on the two-wire link; the clock idles high between frames
module pmbus_host_model #(
   parameter logic [6:0] ADDR = 7'h2a
) (
   input wire logic i_sys_clk,
   input wire logic i_sda_line,
   output logic o_scl,
   output logic o_sda_low
);
   initial begin
      o_scl = 1'b1;
      o_sda_low = 1'b0;
   end
   ////////////////////////////////////////
   // Quarter of the 320 ns link period
   task automatic q();
      repeat (2) @(negedge i_sys_clk);
   endtask
   // Data changes in the low phase, sampled late in the high phase
   task automatic bit_io(input logic b, output logic r);
      o_scl = 1'b0;
      q();
      o_sda_low = ~b;
      q();
      o_scl = 1'b1;
      q();
      q();
      r = i_sda_line;
   endtask
   // Restart lowers the clock first so data may rise safely
   task automatic start(input logic rep);
      if (rep) begin
         o_scl = 1'b0;
         q();
      end
      o_sda_low = 1'b0;
      q();
      o_scl = 1'b1;
      q();
      o_sda_low = 1'b1;
      q();
   endtask
   task automatic stop();
      o_scl = 1'b0;
      q();
      o_sda_low = 1'b1;
      q();
      o_scl = 1'b1;
      q();
      o_sda_low = 1'b0;
      q();
   endtask
   // Eight bits then the acknowledge slot; hb high releases it
   task automatic byte_io(input logic [7:0] b, input logic hb, output logic [7:0] r, output logic nak);
      for (int i = 7; i >= 0; i--) bit_io(b[i], r[i]);
      bit_io(hb, nak);
   endtask
   ////////////////////////////////////////
   // Write of n data bytes; n of zero is a send-byte
   task automatic write_cmd(input logic [6:0] a, input logic [7:0] c, input logic [15:0] d, input int n,
                            output logic ok);
      logic [7:0] r;
      logic k;
      start(1'b0);
      byte_io({a, 1'b0}, 1'b1, r, k);
      ok = ~k;
      byte_io(c, 1'b1, r, k);
      ok &= ~k;
      for (int i = 0; i < n; i++) begin
         byte_io(d[8*i+:8], 1'b1, r, k);
         ok &= ~k;
      end
      stop();
   endtask
   // Word read, low byte first, host ends with a refusal
   task automatic read_word(input logic [7:0] c, output logic [15:0] d);
      logic [7:0] r;
      logic k;
      start(1'b0);
      byte_io({ADDR, 1'b0}, 1'b1, r, k);
      byte_io(c, 1'b1, r, k);
      start(1'b1);
      byte_io({ADDR, 1'b1}, 1'b1, r, k);
      byte_io(8'hff, 1'b0, d[7:0], k);
      byte_io(8'hff, 1'b1, d[15:8], k);
      stop();
   endtask
endmodule // pmbus_host_model
`default_nettype wire

// >>> testbench/vout_setpoint_and_status_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module vout_setpoint_and_status_regs_tb_top;
   import vout_regs_pkg::*;
   localparam logic [6:0] ADDR = 7'h2a;
   typedef struct {logic [7:0] c; int n; logic [15:0] d; logic [15:0] e;} row_t;
   logic sys_clk, resetn, scl, sda_low, sda_out, sda_oe_n, alert_n, on_cmd, tristated, ok;
   logic [1:0] strap_slew, strap_vout;
   logic [3:0] margin_sel;
   fault_t faults;
   logic [9:0] vref;
   logic [7:0] status;
   logic [15:0] rd;
   wire logic sda_line;
   int err_count, num_checks, cycles, n;
   logic [9:0] strap_v[4] = '{STRAP_VOUT_0, STRAP_VOUT_1, STRAP_VOUT_2, STRAP_VOUT_3};
   logic [3:0] mcode[6] = '{4'h5, 4'h9, 4'h6, 4'ha, 4'h0, 4'h3};
   logic [9:0] mexp[6] = '{10'h17c, 10'h184, 10'h17c, 10'h184, 10'h182, 10'h182};
   row_t rows[11] = '{'{CMD_VOUT_FORMAT, 0, 16'h0, 16'h0017}, '{CMD_VOUT_SETPOINT, 0, 16'h0, 16'h0180},
      '{CMD_VOUT_FORMAT, 2, 16'h00ff, 16'h0017}, '{CMD_VOUT_SETPOINT, 2, 16'hfd82, 16'h0182},
      '{CMD_VOUT_SETPOINT, 1, 16'h0033, 16'h0182}, '{CMD_MARGIN_LOW, 2, 16'h0133, 16'h0133},
      '{CMD_MARGIN_HIGH, 2, 16'h0266, 16'h0266}, '{CMD_MARGIN_HIGH, 2, 16'h0184, 16'h0184},
      '{CMD_MARGIN_LOW, 2, 16'h017c, 16'h017c}, '{CMD_STATUS, 2, 16'hffff, 16'h0000},
      '{8'h7f, 0, 16'h0, 16'h0000}};
   // Open-drain data line with its pull-up
   assign sda_line = ~sda_low & (sda_oe_n | sda_out);
   vout_setpoint_and_status_regs i_vout_setpoint_and_status_regs (
      .i_sys_clk(sys_clk), .i_resetn(resetn), .i_scl(scl), .i_sda(sda_line), .o_sda(sda_out),
      .o_sda_oe_n(sda_oe_n), .o_alert_n(alert_n), .i_strap_slew(strap_slew), .i_strap_vout(strap_vout),
      .i_on_cmd(on_cmd), .i_margin_sel(margin_sel), .i_tristated(tristated), .i_faults(faults),
      .o_vref(vref), .o_status(status));
   pmbus_host_model i_pmbus_host_model (.i_sys_clk(sys_clk), .i_sda_line(sda_line), .o_scl(scl),
      .o_sda_low(sda_low));
   ////////////////////////////////////////
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   // Hang guard, well above the expected run length
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         err_count++;
         tally_and_finish();
      end
   end
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   // Straps only matter in the first cycles after reset is released
   task automatic rst(input logic [1:0] s);
      resetn = 1'b0;
      strap_vout = s;
      strap_slew = s;
      repeat (16) @(negedge sys_clk);
      chk({8'h0, status}, 16'h0040, "reset status");
      chk({6'h0, vref}, 16'h0, "reset vref");
      resetn = 1'b1;
      repeat (12) @(negedge sys_clk);
      chk({6'h0, vref}, {6'h0, strap_v[s]}, "strap vref");
   endtask
   // Bounded wait for the reference to reach a code
   task automatic wv(input logic [9:0] v);
      n = 0;
      while (vref !== v && n < 2000) begin
         @(negedge sys_clk);
         n++;
      end
   endtask
   task automatic clr();
      i_pmbus_host_model.write_cmd(ADDR, CMD_CLEAR_FAULTS, 16'h0, 0, ok);
      repeat (8) @(negedge sys_clk);
   endtask
   ////////////////////////////////////////
   initial begin
      {resetn, on_cmd, tristated, err_count, num_checks} = '0;
      {strap_slew, strap_vout, margin_sel, faults} = '0;
      on_cmd = 1'b1;
      // First step is immediate, so time the gap between later steps
      for (int s = 0; s < 4; s++) begin
         rst(2'(s));
         i_pmbus_host_model.write_cmd(ADDR, CMD_VOUT_SETPOINT, {6'h0, strap_v[s] + 10'h3}, 2, ok);
         wv(strap_v[s] + 10'h2);
         wv(strap_v[s] + 10'h3);
         chk(16'(n), 16'(STEP_BASE_CYC << s), "step interval");
         chk({6'h0, vref}, {6'h0, strap_v[s] + 10'h3}, "final vref");
      end
      $display("test steps done");
      rst(2'h1);
      foreach (rows[i]) begin
         if (rows[i].n > 0) i_pmbus_host_model.write_cmd(ADDR, rows[i].c, rows[i].d, rows[i].n, ok);
         i_pmbus_host_model.read_word(rows[i].c, rd);
         chk(rd, rows[i].e, "register row");
      end
      $display("test rows done");
      foreach (mcode[i]) begin
         margin_sel = mcode[i];
         wv(mexp[i]);
         chk({6'h0, vref}, {6'h0, mexp[i]}, "margin select");
      end
      i_pmbus_host_model.write_cmd(7'h2b, CMD_MARGIN_LOW, 16'h0150, 2, ok);
      chk({15'h0, ok}, 16'h0, "foreign address acked");
      i_pmbus_host_model.read_word(CMD_MARGIN_LOW, rd);
      chk(rd, 16'h017c, "foreign write landed");
      $display("test margins done");
      // Pulse each detector; the bit must outlive the pulse
      for (int b = 0; b < 6; b++) begin
         faults = fault_t'(6'h1 << b);
         repeat (3) @(negedge sys_clk);
         faults = '0;
         repeat (3) @(negedge sys_clk);
         chk({8'h0, status}, 16'(8'h1 << b), "sticky bit");
         i_pmbus_host_model.read_word(CMD_STATUS, rd);
         chk(rd, 16'(8'h1 << b), "status read");
         chk({15'h0, alert_n}, 16'h0, "alert set");
         clr();
         chk({7'h0, alert_n, status}, 16'h0100, "cleared");
      end
      on_cmd = 1'b0;
      repeat (3) @(negedge sys_clk);
      chk({15'h0, status[6]}, 16'h1, "off commanded");
      on_cmd = 1'b1;
      tristated = 1'b1;
      repeat (3) @(negedge sys_clk);
      chk({15'h0, status[6]}, 16'h1, "off tristated");
      tristated = 1'b0;
      faults.ov = 1'b1;
      repeat (3) @(negedge sys_clk);
      chk({8'h0, status}, 16'h0020, "driven in fault");
      clr();
      chk({7'h0, alert_n, status}, 16'h0020, "persisting fault");
      faults.ov = 1'b0;
      $display("test status done");
      tally_and_finish();
   end
endmodule // vout_setpoint_and_status_regs_tb_top
`default_nettype wire
